// ==== rtl/safety_sensor_diag.sv ====
// Condition tracker of a coded safety sensor: indicator lamps,
// diagnostic output and enables of the two safety outputs.
// Assumes actuator sensing and fault detection happen upstream and arrive
// as synchronous levels; the controller reads the outputs as levels.
`timescale 1ns/10ps
module safety_sensor_diag
  import sensor_diag_pkg::*;
#(
  parameter int unsigned DIAG_CYC  = DIAG_DELAY_CYC,  // Fault to diag off
  parameter int unsigned FAIL_CYC  = FAIL_DELAY_CYC,  // Fault to outputs off
  parameter int unsigned LIMIT_CYC = LIMIT_HALF_CYC,  // Half 2 Hz period
  parameter int unsigned TEST_PER  = SELFTEST_PER_CYC // Self-test period
)(
  input  wire logic   clk,          // System clock, 10 MHz
  input  wire logic   sys_rst,      // Synchronous reset, active high
  input  wire logic   act_present,  // Valid coded actuator in range
  input  wire logic   act_limit,    // Actuator near edge of range
  input  wire logic   chain_ok,     // Both upstream safety inputs high
  input  wire fault_t fault_code,   // Active fault class, FLT_NONE if none
  output logic        led_green,    // Green indicator
  output logic        led_yellow,   // Yellow indicator
  output logic        led_red,      // Red indicator
  output logic        diag_out,     // Non-safety diagnostic output
  output logic        safety_out_a, // Safety output channel A
  output logic        safety_out_b  // Safety output channel B
);
  flash_if fl();

  cond_t            st_r;
  cond_t            st_nxt;
  logic [CNT_W-1:0] flt_tmr_r;   // Time since fault became active
  logic [CNT_W-1:0] blink_tmr_r; // Free running blink base
  logic [CNT_W-1:0] lim_tmr_r;   // 2 Hz diagnostic pulse base
  logic [CNT_W-1:0] test_tmr_r;  // Self-test schedule
  logic             yel_ph_r;
  logic             lim_ph_r;
  logic             test_gap_r;
  fault_t           code_r;
  logic             led_green_r, led_yellow_r, led_red_r;
  logic             diag_r, sa_r, sb_r;

  // Saturating counter reached its limit
  function automatic logic reached(input logic [CNT_W-1:0] v,
                                   input int unsigned lim);
    reached = (v >= CNT_W'(lim));
  endfunction

  wire logic fault_act   = (fault_code != FLT_NONE);
  wire logic diag_expired = reached(flt_tmr_r, DIAG_CYC);
  wire logic fail_expired = reached(flt_tmr_r, FAIL_CYC);
  wire logic analysing   = fault_act && !diag_expired;

  // Condition transitions
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_READY, ST_ACT, ST_LIMIT: begin
        if (fault_act)
          st_nxt = act_present ? ST_WARN : ST_FAIL;
        else if (!act_present)
          st_nxt = ST_READY;
        else if (act_limit)
          st_nxt = ST_LIMIT;
        else
          st_nxt = ST_ACT;
      end
      ST_WARN: begin
        if (!fault_act)
          st_nxt = act_present ? ST_ACT : ST_READY;
        else if (fail_expired || !act_present)
          st_nxt = ST_FAIL;
      end
      ST_FAIL: begin
        // Failure clears only once the fault itself has gone
        if (!fault_act)
          st_nxt = ST_READY;
      end
      default: st_nxt = ST_READY;
    endcase
  end

  // Condition register and fault age; fault must be continuous
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r      <= ST_READY;
      flt_tmr_r <= '0;
      code_r    <= FLT_NONE;
    end else begin
      st_r <= st_nxt;
      if (!fault_act)
        flt_tmr_r <= '0;
      else if (!fail_expired)
        flt_tmr_r <= flt_tmr_r + 1'b1;
      if (fault_act)
        code_r <= fault_code;
    end
  end

  // Free running blink base for yellow flashing only; 2 Hz diagnostic pulsing has its own base below
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blink_tmr_r <= '0;
      yel_ph_r    <= 1'b1;
    end else if (reached(blink_tmr_r, YEL_BLINK_CYC - 1)) begin
      blink_tmr_r <= '0;
      yel_ph_r    <= !yel_ph_r;
    end else begin
      blink_tmr_r <= blink_tmr_r + 1'b1;
    end
  end

  // Restarted on leaving limit range so each pulse train starts high
  always_ff @(posedge clk) begin
    if (sys_rst || st_r != ST_LIMIT) begin
      lim_tmr_r <= '0;
      lim_ph_r  <= 1'b1;
    end else if (reached(lim_tmr_r, LIMIT_CYC - 1)) begin
      lim_tmr_r <= '0;
      lim_ph_r  <= !lim_ph_r;
    end else begin
      lim_tmr_r <= lim_tmr_r + 1'b1;
    end
  end

  // Internal self-test: short dropout of both outputs, well under 2 ms
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      test_tmr_r <= '0;
      test_gap_r <= 1'b0;
    end else if (reached(test_tmr_r, TEST_PER - 1)) begin
      test_tmr_r <= '0;
      test_gap_r <= 1'b1;
    end else begin
      test_tmr_r <= test_tmr_r + 1'b1;
      if (reached(test_tmr_r, SELFTEST_CYC - 1))
        test_gap_r <= 1'b0;
    end
  end

  // Red flasher runs once analysis ends
  assign fl.run  = fault_act && diag_expired && (st_r == ST_WARN);
  assign fl.code = code_r;

  red_flasher u_flash (
    .clk     (clk),
    .sys_rst (sys_rst),
    .fl      (fl)
  );

  wire logic outs_on = chain_ok && !test_gap_r &&
                       (st_r == ST_ACT || st_r == ST_LIMIT ||
                        st_r == ST_WARN);
  wire logic red_nxt = (st_r == ST_FAIL) ||
                       (st_r == ST_WARN && (analysing || fl.red));
  // Diagnostic is off after 10 s of fault, before the one-minute shutdown
  wire logic diag_nxt = (st_r == ST_ACT) ||
                        (st_r == ST_LIMIT && lim_ph_r) ||
                        (fault_act && !diag_expired &&
                         st_r == ST_WARN);

  // Output flip-flops; diag is informational only and never gates safety
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      led_green_r  <= 1'b0;
      led_yellow_r <= 1'b0;
      led_red_r    <= 1'b0;
      diag_r       <= 1'b0;
      sa_r         <= 1'b0;
      sb_r         <= 1'b0;
    end else begin
      led_green_r  <= (st_r == ST_READY);
      led_yellow_r <= (st_r == ST_ACT) ||
                      (st_r == ST_LIMIT && yel_ph_r);
      led_red_r    <= red_nxt;
      diag_r       <= diag_nxt;
      sa_r         <= outs_on;
      sb_r         <= outs_on;
    end
  end

  assign led_green    = led_green_r;
  assign led_yellow   = led_yellow_r;
  assign led_red      = led_red_r;
  assign diag_out     = diag_r;
  assign safety_out_a = sa_r;
  assign safety_out_b = sb_r;
endmodule

// ==== shared/sensor_diag_pkg.sv ====
// Constants, types and timing for the sensor diagnostics block.
// Assumes a 10 MHz system clock; all times are converted to cycles here.
// Behaviour
// - Ready, not actuated: green lamp, safety and diagnostic outputs low.
// - Actuator in range: yellow lamp, safety outputs on, diagnostic high.
// - Actuator near range edge: yellow flashes, safety outputs stay enabled.
// - Limit range pulses the diagnostic output at 2 Hz instead of steady high.
// - Fault with actuator in range shows steady red during analysis, then repeating red flash counts.
// - Flash count: 1 out A, 2 out B, 3 cross-wire, 4 overtemp, 5 coding.
// - Actuated with fault keeps safety outputs until fault persists one minute.
// - Warning lasting one minute becomes failure: steady red, outputs off.
// - Diagnostic output drops ten seconds after fault becomes active.
// - Diagnostic output signals fault before safety outputs are disabled.
package sensor_diag_pkg;
  localparam int unsigned CLK_HZ          = 10000000;
  // Times in their own units
  localparam int unsigned DIAG_DELAY_S    = 10;
  localparam int unsigned FAIL_DELAY_MIN  = 1;
  localparam int unsigned LIMIT_PULSE_HZ  = 2;
  localparam int unsigned FLASH_ON_MS     = 200;
  localparam int unsigned FLASH_GAP_MS    = 300;
  localparam int unsigned FLASH_PAUSE_MS  = 1500;
  localparam int unsigned YEL_BLINK_MS    = 250;
  localparam int unsigned SELFTEST_MS     = 1;
  localparam int unsigned SELFTEST_EVERY_MS = 1000;
  // Derived cycle counts
  localparam int unsigned DIAG_DELAY_CYC  = DIAG_DELAY_S * CLK_HZ;
  localparam int unsigned FAIL_DELAY_CYC  = FAIL_DELAY_MIN * 60 * CLK_HZ;
  localparam int unsigned LIMIT_HALF_CYC  = CLK_HZ / (2 * LIMIT_PULSE_HZ);
  localparam int unsigned FLASH_ON_CYC    = FLASH_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_GAP_CYC   = FLASH_GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_PAUSE_CYC = FLASH_PAUSE_MS * (CLK_HZ / 1000);
  localparam int unsigned YEL_BLINK_CYC   = YEL_BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned SELFTEST_CYC    = SELFTEST_MS * (CLK_HZ / 1000);
  localparam int unsigned SELFTEST_PER_CYC = SELFTEST_EVERY_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W           = 32;

  // Fault classes, value equals the red flash count
  typedef enum logic [2:0] {
    FLT_NONE   = 3'h0,
    FLT_OUT_A  = 3'h1,
    FLT_OUT_B  = 3'h2,
    FLT_CROSS  = 3'h3,
    FLT_TEMP   = 3'h4,
    FLT_CODING = 3'h5
  } fault_t;

  // Sensor condition
  typedef enum logic [4:0] {
    ST_READY  = 5'h01,
    ST_ACT    = 5'h02,
    ST_LIMIT  = 5'h04,
    ST_WARN   = 5'h08,
    ST_FAIL   = 5'h10
  } cond_t;
endpackage

// ==== shared/flash_if.sv ====
// Request and answer between the condition tracker and the red flasher.
// Assumes both ends run on the one system clock.
`timescale 1ns/10ps
interface flash_if;
  import sensor_diag_pkg::*;
  logic   run;   // Flash sequence wanted
  fault_t code;  // Number of pulses per sequence
  logic   red;   // Red lamp state from the flasher
  modport ctrl (output run, output code, input red);
  modport gen  (input run, input code, output red);
endinterface

// ==== rtl/red_flasher.sv ====
// Red flash code generator: repeats N pulses then a long pause.
// Assumes code is stable while run is high.
`timescale 1ns/10ps
module red_flasher
  import sensor_diag_pkg::*;
(
  input  wire logic clk,     // System clock
  input  wire logic sys_rst, // Synchronous reset, active high
  flash_if.gen      fl       // Flash request and lamp
);
  typedef enum logic [2:0] {
    F_IDLE = 3'h1,
    F_ON   = 3'h2,
    F_OFF  = 3'h4
  } fstate_t;

  fstate_t          st_r;
  logic [CNT_W-1:0] tmr_r;
  logic [2:0]       cnt_r;

  wire logic tmr_done = (tmr_r == '0);
  wire logic last     = (cnt_r == 3'(fl.code) - 3'h1);

  // Pulse, gap and pause are separate constants so counts stay readable
  always_ff @(posedge clk) begin
    if (sys_rst || !fl.run) begin
      st_r  <= F_IDLE;
      tmr_r <= '0;
      cnt_r <= 3'h0;
    end else begin
      case (st_r)
        F_IDLE: begin
          st_r  <= F_ON;
          tmr_r <= CNT_W'(FLASH_ON_CYC - 1);
          cnt_r <= 3'h0;
        end
        F_ON: begin
          if (tmr_done) begin
            st_r  <= F_OFF;
            tmr_r <= last ? CNT_W'(FLASH_PAUSE_CYC - 1)
                          : CNT_W'(FLASH_GAP_CYC - 1);
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        F_OFF: begin
          if (tmr_done) begin
            st_r  <= F_ON;
            tmr_r <= CNT_W'(FLASH_ON_CYC - 1);
            cnt_r <= last ? 3'h0 : cnt_r + 3'h1;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        default: st_r <= F_IDLE;
      endcase
    end
  end

  assign fl.red = (st_r == F_ON);
endmodule

// ==== dv/plc_model.sv ====
// Controller model at the far side: watches the safety output pair.
// Assumes the 10 MHz system clock; DROP_MAX is 2 ms in cycles.
`timescale 1ns/10ps
module plc_model #(
  parameter int unsigned DROP_MAX = 20000 // Longest tolerated dropout
)(
  input  wire logic clk,          // System clock
  input  wire logic sys_rst,      // Synchronous reset, active high
  input  wire logic safety_out_a, // Safety channel A
  input  wire logic safety_out_b, // Safety channel B
  input  wire logic diag_out,     // Informational only
  output int        drops         // Short dropouts ridden through
);
  int unsigned low_r;
  logic        run_r;
  // Diag never enters the run decision, it is not a safety signal
  wire         diag_unused = diag_out;
  // A short both-low gap is a self-test, so the machine keeps running
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_r <= 0;
      drops <= 0;
      run_r <= 1'b0;
    end else if (safety_out_a && safety_out_b) begin
      if (run_r && low_r > 0 && low_r <= DROP_MAX) begin
        drops <= drops + 1;
      end
      low_r <= 0;
      run_r <= 1'b1;
    end else begin
      low_r <= low_r + 1;
      if (low_r >= DROP_MAX) begin
        run_r <= 1'b0;
      end
    end
  end
endmodule

// ==== dv/safety_sensor_diag_properties.sv ====
// Concurrent checks on the ports of the sensor diagnostics block.
// Assumes one clock; bound to every instance of the block.
`timescale 1ns/10ps
module safety_sensor_diag_properties
  import sensor_diag_pkg::*;
#(
  parameter int unsigned DIAG_CYC  = DIAG_DELAY_CYC, // Fault to diag off
  parameter int unsigned FAIL_CYC  = FAIL_DELAY_CYC, // Fault to outputs off
  parameter int unsigned LIMIT_CYC = LIMIT_HALF_CYC, // Half 2 Hz period
  parameter int unsigned TEST_PER  = SELFTEST_PER_CYC // Self-test period
)(
  input wire logic   clk,          // System clock
  input wire logic   sys_rst,      // Synchronous reset
  input wire logic   act_present,  // Actuator in range
  input wire logic   act_limit,    // Actuator near edge
  input wire logic   chain_ok,     // Upstream inputs high
  input wire fault_t fault_code,   // Active fault class
  input wire logic   led_green,    // Green lamp
  input wire logic   led_yellow,   // Yellow lamp
  input wire logic   led_red,      // Red lamp
  input wire logic   diag_out,     // Diagnostic output
  input wire logic   safety_out_a, // Safety channel A
  input wire logic   safety_out_b  // Safety channel B
);
  int unsigned age_r;
  int unsigned wage_r;
  int unsigned stab_r;
  logic        diag_q_r;
  wire         flt = (fault_code != FLT_NONE);
  wire         lim = act_present && act_limit && !flt;
  // Fault age, actuated fault age and steady-diag run in the limit range
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      age_r    <= 0;
      wage_r   <= 0;
      stab_r   <= 0;
      diag_q_r <= 1'b0;
    end else begin
      age_r    <= flt ? age_r + 1 : 0;
      wage_r   <= (flt && act_present) ? wage_r + 1 : 0;
      stab_r   <= (lim && diag_out == diag_q_r) ? stab_r + 1 : 0;
      diag_q_r <= diag_out;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_ready_quiet: assert property (
    led_green |-> !diag_out && !safety_out_a && !safety_out_b)
    else $error("Ready shows an active output");
  chk_act_on: assert property (
    (act_present && !act_limit && !flt) [*4] |-> led_yellow && diag_out)
    else $error("Actuated without yellow or diag");
  chk_out_pair: assert property (
    safety_out_a == safety_out_b)
    else $error("Safety channels differ");
  chk_limit_pulse: assert property (
    stab_r <= LIMIT_CYC + 3)
    else $error("Diag not pulsing in limit range");
  chk_red_analysis: assert property (
    age_r inside {[3:DIAG_CYC - 3]} |-> led_red && !led_green)
    else $error("Red not steady during analysis");
  chk_diag_warn: assert property (
    wage_r == age_r && wage_r inside {[3:DIAG_CYC - 3]} |-> diag_out)
    else $error("Diag dropped during analysis");
  chk_diag_off: assert property (
    age_r >= DIAG_CYC + 3 |-> !diag_out)
    else $error("Diag still high after analysis");
  chk_fail_off: assert property (
    age_r >= FAIL_CYC + 3 |-> !safety_out_a && led_red && !led_yellow)
    else $error("Outputs on after fault minute");
  chk_fault_idle: assert property (
    (flt && !act_present) [*3] |-> led_red && !diag_out && !safety_out_b)
    else $error("Unactuated fault not in failure");
endmodule
bind safety_sensor_diag safety_sensor_diag_properties #(
  .DIAG_CYC(DIAG_CYC), .FAIL_CYC(FAIL_CYC),
  .LIMIT_CYC(LIMIT_CYC), .TEST_PER(TEST_PER)
) u_props (.clk, .sys_rst, .act_present, .act_limit, .chain_ok,
  .fault_code, .led_green, .led_yellow, .led_red, .diag_out,
  .safety_out_a, .safety_out_b);

// ==== dv/safety_sensor_diag_tb.sv ====
// Self-checking bench for the sensor diagnostics block.
// Assumes short delay parameters; inputs change at the falling edge.
`timescale 1ns/10ps
module safety_sensor_diag_tb;
  import sensor_diag_pkg::*;
  localparam int DC = 20;
  localparam int FC = 60;
  localparam int TP = 40000;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        act_present = 1'b0;
  logic        act_limit = 1'b0;
  logic        chain_ok = 1'b1;
  fault_t      fault_code = FLT_NONE;
  logic        led_green, led_yellow, led_red;
  logic        diag_out, safety_out_a, safety_out_b, prev;
  logic [15:0] lfsr_r = 16'h9FA9;
  int          fail_count = 0;
  int          compares = 0;
  int          cyc = 0;
  int          drops, n;
  wire  [5:0]  outs = {led_green, led_yellow, led_red, diag_out,
                       safety_out_a, safety_out_b};
  safety_sensor_diag #(.DIAG_CYC(DC), .FAIL_CYC(FC), .LIMIT_CYC(5),
    .TEST_PER(TP)) u_dut (.clk, .sys_rst, .act_present, .act_limit,
    .chain_ok, .fault_code, .led_green, .led_yellow, .led_red,
    .diag_out, .safety_out_a, .safety_out_b);
  plc_model u_plc (.clk, .sys_rst, .safety_out_a, .safety_out_b,
    .diag_out, .drops);
  always #50 clk = ~clk;
  task automatic complete_run();
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Cut a hang short well past the planned run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(int k);
    repeat (k) @(negedge clk);
  endtask
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Lamp and output levels {g,y,r,diag,a,b}; after analysis red follows
  // the first flash pulse, which outlasts any short run of this bench
  function automatic logic [5:0] model(bit act, int flt, int age);
    if (flt == 0) return act ? 6'h17 : 6'h20;
    if (!act || age >= FC) return 6'h08;
    if (age < DC) return 6'h0F;
    return (age < DC + FLASH_ON_CYC) ? 6'h0B : 6'h03;
  endfunction
  initial begin
    step(5);
    check(outs, 6'h00);
    sys_rst = 1'b0;
    step(3);
    check(outs, model(0, 0, 0));
    for (int c = 1; c <= 5; c++) begin
      act_present = 1'b1;
      step(4);
      check(outs, model(1, 0, 0));
      act_limit = 1'b1;
      step(4);
      check(outs & 6'h3B, 6'h13);
      n = 0;
      prev = diag_out;
      repeat (40) begin
        @(negedge clk);
        if (diag_out !== prev) n++;
        prev = diag_out;
      end
      check(8'(n inside {[7:9]}), 8'h01);
      act_limit = 1'b0;
      lfsr_r = lfsr_next(lfsr_r);
      step(2 + lfsr_r[6:4]);
      // Short fault burst: its age must be forgotten once it clears
      fault_code = fault_t'(c);
      step(1 + lfsr_r[3:0]);
      fault_code = FLT_NONE;
      step(3);
      fault_code = fault_t'(c);
      step(5);
      check(outs, model(1, c, 5));
      step(DC - 8);
      check(outs, model(1, c, DC - 3));
      step(6);
      check(outs, model(1, c, DC + 3));
      step(FC - DC);
      check(outs, model(1, c, FC + 3));
      act_present = 1'b0;
      step(3);
      check(outs, model(0, c, 0));
      fault_code = FLT_NONE;
      step(4);
      check(outs, model(0, 0, 0));
    end
    // Stay actuated long enough for exactly one self-test dropout
    act_present = 1'b1;
    step(4);
    n = drops;
    step(TP + 12000);
    check(8'(drops - n), 8'h01);
    check(outs, model(1, 0, 0));
    // A broken upstream chain drops both channels, lamps stay as they are
    chain_ok = 1'b0;
    step(3);
    check(outs, 6'h14);
    chain_ok = 1'b1;
    step(3);
    check(outs, model(1, 0, 0));
    complete_run();
  end
endmodule
